// *** rtl/sac_conv_ctrl.sv ***
// Control logic for a 12-bit successive-approximation converter.
// Assumes control fields arrive as write strobes with data, the RTC match
// level and analog comparator come from other domains, no register bus.
//
// Function
// - Clock gate bit is set by every reset; clearing it stops the module.
// - Five-bit channel select; 0..23 external, all ones turns converter off.
// - Reserved codes still convert; the value is undefined.
// - Code 11010 routes the temperature sensor to the converter input.
// - Conversion clock from bus, bus halved, local async or alternate.
// - Hardware trigger mode starts a conversion on each RTC match.
// - RTC match triggers regardless of the RTC interrupt enable.
// - Hardware triggering works in run, wait and stop3.
// - One interrupt line shared by completion and compare events.
// - Linear successive approximation, one bit per step, 12 bits.
// - Result right-justified at 12, 10 or 8 bits, upper bits zero.
// - Single or continuous conversion; single returns to idle itself.
// - Optional compare, less-than or greater-or-equal, can interrupt.
// - Completion sets the complete flag, with compare on only when the compare holds; enabled flag asserts interrupt.
// - Converter keeps running in wait and stop3.
// - Input multiplexer addresses 28 channels, 0 through 27.
// - Control-one write aborts, then restarts in software mode unless channel is all ones.
// - Software mode starts on control-one write, hardware mode on trigger.
// - Complete flag clears on control-one write or low result byte read.
`timescale 1ns/100ps
module sac_conv_ctrl
    import sac_pkg::*;
#(
    parameter int unsigned WIDTH = RES_BITS
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Peripheral clock gate
    input wire logic gate_wr_in,
    input wire logic gate_data_in,
    output logic bus_clk_en_out,
    // Control writes
    input wire logic csc1_wr_in,
    input wire sac_csc1_t csc1_in,
    input wire logic csc2_wr_in,
    input wire sac_csc2_t csc2_in,
    input wire logic cfg_wr_in,
    input wire sac_cfg_t cfg_in,
    input wire logic cmp_val_wr_in,
    input wire logic [WIDTH-1:0] cmp_val_in,
    input wire logic res_low_rd_in,
    // Triggers, clock sources and power state
    input wire logic hw_trigger_input_in,
    input wire logic local_async_clock_in,
    input wire logic alternate_conv_clock_in,
    input wire sac_pwr_t power_mode_in,
    // Analog comparator
    input wire logic comparator_in,
    // Analog front end controls
    output logic [WIDTH-1:0] dac_code_out,
    output logic sample_out,
    output logic [4:0] mux_channel_out,
    output logic temp_sensor_sel_out,
    output logic converter_on_out,
    // Status and result
    output sac_csc1_t csc1_out,
    output sac_csc2_t csc2_out,
    output sac_cfg_t cfg_out,
    output logic [WIDTH-1:0] result_out,
    output logic conv_complete_flag_out,
    output logic active_out,
    output logic irq_out
);

    localparam int unsigned NSYNC = 4;
    localparam int unsigned SYN_TRIG = 0;
    localparam int unsigned SYN_ASYNC = 1;
    localparam int unsigned SYN_ALT = 2;
    localparam int unsigned SYN_CMP = 3;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, two flops each
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] sync_prev;

    assign raw_in[SYN_TRIG] = hw_trigger_input_in;
    assign raw_in[SYN_ASYNC] = local_async_clock_in;
    assign raw_in[SYN_ALT] = alternate_conv_clock_in;
    assign raw_in[SYN_CMP] = comparator_in;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // First stage feeds only the second stage
            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_prev[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_prev[gi] <= sync_b[gi];
                end
            end
        end
    endgenerate

    // Rising edges of synchronised levels
    logic trig_edge;
    logic async_edge;
    logic alt_edge;
    assign trig_edge = sync_b[SYN_TRIG] & ~sync_prev[SYN_TRIG];
    assign async_edge = sync_b[SYN_ASYNC] & ~sync_prev[SYN_ASYNC];
    assign alt_edge = sync_b[SYN_ALT] & ~sync_prev[SYN_ALT];

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    logic gate, next_gate;
    sac_csc1_t csc1, next_csc1;
    sac_csc2_t csc2, next_csc2;
    sac_cfg_t cfg, next_cfg;
    logic [WIDTH-1:0] cmp_val, next_cmp_val;
    logic wr1;

    // Gate clear drops all writes but its own
    assign wr1 = csc1_wr_in & gate;

    always_comb begin
        next_gate = gate_wr_in ? gate_data_in : gate;
        next_csc1 = wr1 ? csc1_in : csc1;
        next_csc2 = (csc2_wr_in & gate) ? csc2_in : csc2;
        next_cfg = (cfg_wr_in & gate) ? cfg_in : cfg;
        next_cmp_val = (cmp_val_wr_in & gate) ? cmp_val_in : cmp_val;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            gate <= GATE_RESET;
            csc1 <= CSC1_RESET;
            csc2 <= CSC2_RESET;
            cfg <= CFG_RESET;
            cmp_val <= CMP_VAL_RESET;
        end else begin
            gate <= next_gate;
            csc1 <= next_csc1;
            csc2 <= next_csc2;
            cfg <= next_cfg;
            cmp_val <= next_cmp_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock tick selection
    logic half, next_half;
    logic tick;

    always_comb begin
        next_half = ~half;
        unique case (cfg.clk_select)
            CLK_BUS: tick = gate;
            CLK_BUS_DIV2: tick = gate & half;
            CLK_ALT: tick = gate & alt_edge;
            CLK_ASYNC: tick = gate & async_edge;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            half <= 1'b0;
        end else begin
            half <= next_half;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start, abort and continuous sequencing
    logic ch_off;
    logic stop2;
    logic hw_go;
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic [WIDTH-1:0] raw_result;
    logic armed, next_armed;

    assign ch_off = (csc1.channel_select == CH_DISABLED);
    // Only the deepest stop removes the converter; run, wait and stop3 go on
    assign stop2 = (power_mode_in == SAC_PWR_STOP2);
    // Match edge alone decides; RTC interrupt enable never enters here
    assign hw_go = csc2.trigger_select & trig_edge & ~ch_off;

    always_comb begin
        next_armed = armed;
        abort = 1'b0;
        start = 1'b0;
        if (!gate || stop2) begin
            abort = 1'b1;
            next_armed = 1'b0;
        end else if (wr1) begin
            // Any write kills the running conversion first
            abort = (csc1_in.channel_select == CH_DISABLED);
            start = ~csc2.trigger_select &
                (csc1_in.channel_select != CH_DISABLED);
            next_armed = start & csc1_in.continuous;
            if (csc2.trigger_select) begin
                abort = 1'b1;
            end
        end else if (ch_off) begin
            abort = busy;
            next_armed = 1'b0;
        end else if (hw_go) begin
            start = 1'b1;
            next_armed = csc1.continuous;
        end else if (done) begin
            // Single mode just drops back to idle here
            start = armed & csc1.continuous;
            next_armed = armed & csc1.continuous;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end

    sac_sar_step #(
        .WIDTH(WIDTH)
    ) u_sar (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .start_in(start),
        .abort_in(abort),
        .tick_in(tick),
        .cmp_in(sync_b[SYN_CMP]),
        .trial_out(dac_code_out),
        .sample_out(sample_out),
        .busy_out(busy),
        .done_out(done),
        .result_out(raw_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // Result formatting and compare
    logic [WIDTH-1:0] fmt_result;
    logic cmp_true;
    logic hit;

    always_comb begin
        unique case (cfg.mode)
            MODE_12: fmt_result = raw_result;
            MODE_10: fmt_result = {2'h0, raw_result[WIDTH-1:2]};
            MODE_8: fmt_result = {4'h0, raw_result[WIDTH-1:4]};
            default: fmt_result = raw_result;
        endcase
        // Compare against the value in the chosen result width
        cmp_true = csc2.compare_greater ? (fmt_result >= cmp_val) :
            (fmt_result < cmp_val);
        hit = done & (~csc2.compare_enable | cmp_true);
    end

    ////////////////////////////////////////////////////////////////////////
    // Result, complete flag, activity and interrupt
    logic [WIDTH-1:0] result, next_result;
    logic conv_complete_flag, next_conv_complete_flag;
    logic active, next_active;
    logic irq, next_irq;

    always_comb begin
        next_result = hit ? fmt_result : result;
        // Set beats a same-cycle clear so no completion is lost
        next_conv_complete_flag = hit | (conv_complete_flag & ~(wr1 | res_low_rd_in));
        next_active = start | (active & ~abort & ~done);
        // Single line; a compare hit and a plain completion look alike
        next_irq = next_conv_complete_flag & next_csc1.int_enable;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            result <= '0;
            conv_complete_flag <= 1'b0;
            active <= 1'b0;
            irq <= 1'b0;
        end else begin
            result <= next_result;
            conv_complete_flag <= next_conv_complete_flag;
            active <= next_active;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog mux and power controls
    logic [4:0] mux_ch, next_mux_ch;
    logic temp_sel, next_temp_sel;
    logic conv_on, next_conv_on;

    always_comb begin
        // Reserved codes pass straight through and convert noise
        next_mux_ch = next_csc1.channel_select;
        next_temp_sel = (next_csc1.channel_select == CH_TEMP);
        // Bandgap code relies on software having enabled its buffer
        next_conv_on = next_active;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            mux_ch <= CH_DISABLED;
            temp_sel <= 1'b0;
            conv_on <= 1'b0;
        end else begin
            mux_ch <= next_mux_ch;
            temp_sel <= next_temp_sel;
            conv_on <= next_conv_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive, all from flops
    assign bus_clk_en_out = gate;
    assign csc1_out = csc1;
    assign csc2_out = csc2;
    assign cfg_out = cfg;
    assign result_out = result;
    assign conv_complete_flag_out = conv_complete_flag;
    assign active_out = active;
    assign irq_out = irq;
    assign mux_channel_out = mux_ch;
    assign temp_sensor_sel_out = temp_sel;
    assign converter_on_out = conv_on;

endmodule

// *** include/sac_pkg.sv ***
// Shared constants and carrier types for the converter control block.
// Assumes one 100 MHz system clock and plain control ports, no bus.
package sac_pkg;

    // Clock and timing
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned SAMPLE_TIME_NS = 40;
    localparam int unsigned SAMPLE_CYCLES =
        (SAMPLE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0] SAMPLE_TICKS = 4'(SAMPLE_CYCLES);
    // Comparator path: two sync flops plus one cycle of DAC settle
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    // Converter resolution and channel space
    localparam int unsigned RES_BITS = 12;
    localparam int unsigned CH_COUNT = 28;
    localparam logic [4:0] CH_LAST_EXT = 5'h17;
    localparam logic [4:0] CH_RSVD_A = 5'h18;
    localparam logic [4:0] CH_RSVD_B = 5'h19;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BANDGAP = 5'h1b;
    localparam logic [4:0] CH_RSVD_C = 5'h1c;
    localparam logic [4:0] CH_DISABLED = 5'h1f;

    // Result width select
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;

    // Conversion clock select
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;

    // Reset values
    localparam logic GATE_RESET = 1'b1;
    localparam logic [11:0] CMP_VAL_RESET = 12'h000;

    typedef enum logic [1:0] {
        SAC_PWR_RUN,
        SAC_PWR_WAIT,
        SAC_PWR_STOP3,
        SAC_PWR_STOP2
    } sac_pwr_t;

    typedef struct packed {
        logic int_enable;
        logic continuous;
        logic [4:0] channel_select;
    } sac_csc1_t;

    typedef struct packed {
        logic trigger_select;
        logic compare_enable;
        logic compare_greater;
    } sac_csc2_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] clk_select;
    } sac_cfg_t;

    localparam sac_csc1_t CSC1_RESET = '{1'b0, 1'b0, CH_DISABLED};
    localparam sac_csc2_t CSC2_RESET = '{1'b0, 1'b0, 1'b0};
    localparam sac_cfg_t CFG_RESET = '{MODE_8, CLK_BUS};

endpackage

// *** rtl/sac_sar_step.sv ***
// Successive-approximation sequencer: sample phase then one bit per step.
// Assumes tick_in marks conversion clock steps and cmp_in is synchronised.
`timescale 1ns/100ps
module sac_sar_step
    import sac_pkg::*;
#(
    parameter int unsigned WIDTH = RES_BITS
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Control
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic tick_in,
    input wire logic cmp_in,
    // Analog side and result
    output logic [WIDTH-1:0] trial_out,
    output logic sample_out,
    output logic busy_out,
    output logic done_out,
    output logic [WIDTH-1:0] result_out
);

    typedef enum logic [1:0] {SAC_S_IDLE, SAC_S_SAMPLE, SAC_S_STEP} sac_sar_t;

    localparam logic [WIDTH-1:0] TOP_BIT = {1'b1, {(WIDTH-1){1'b0}}};

    sac_sar_t state, next_state;
    logic [WIDTH-1:0] trial, next_trial;
    logic [WIDTH-1:0] probe, next_probe;
    logic [WIDTH-1:0] result, next_result;
    logic [3:0] samp_cnt, next_samp_cnt;
    logic [1:0] settle, next_settle;
    logic done, next_done;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: probe walks one bit per step, MSB first
    always_comb begin
        next_state = state;
        next_trial = trial;
        next_probe = probe;
        next_result = result;
        next_samp_cnt = samp_cnt;
        next_settle = settle;
        next_done = 1'b0;
        if (abort_in) begin
            next_state = SAC_S_IDLE;
            next_trial = '0;
        end else if (start_in) begin
            next_state = SAC_S_SAMPLE;
            next_samp_cnt = '0;
            next_trial = '0;
        end else begin
            unique case (state)
                SAC_S_IDLE: begin
                end
                SAC_S_SAMPLE: begin
                    if (tick_in) begin
                        if (samp_cnt == SAMPLE_TICKS - 4'h1) begin
                            next_state = SAC_S_STEP;
                            next_probe = TOP_BIT;
                            next_trial = TOP_BIT;
                            next_settle = '0;
                        end else begin
                            next_samp_cnt = samp_cnt + 4'h1;
                        end
                    end
                end
                SAC_S_STEP: begin
                    // Wait out comparator latency before judging a bit
                    if (settle != SETTLE_CYCLES) begin
                        next_settle = settle + 2'h1;
                    end else if (tick_in) begin
                        next_trial = cmp_in ? trial : (trial & ~probe);
                        next_settle = '0;
                        if (probe[0]) begin
                            next_state = SAC_S_IDLE;
                            next_result = next_trial;
                            next_done = 1'b1;
                        end else begin
                            next_probe = probe >> 1;
                            next_trial = next_trial | (probe >> 1);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state <= SAC_S_IDLE;
            trial <= '0;
            probe <= '0;
            result <= '0;
            samp_cnt <= '0;
            settle <= '0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            trial <= next_trial;
            probe <= next_probe;
            result <= next_result;
            samp_cnt <= next_samp_cnt;
            settle <= next_settle;
            done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state flops
    assign trial_out = trial;
    assign sample_out = (state == SAC_S_SAMPLE);
    assign busy_out = (state != SAC_S_IDLE);
    assign done_out = done;
    assign result_out = result;

endmodule

// *** bench/sac_conv_ctrl_sva.sv ***
// Port checker for the converter control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module sac_conv_ctrl_sva
    import sac_pkg::*;
#(
    parameter int unsigned WIDTH = RES_BITS
) (
    // Clock, reset and controls
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic gate_wr_in,
    input wire logic gate_data_in,
    input wire logic csc1_wr_in,
    input wire sac_csc1_t csc1_in,
    input wire logic res_low_rd_in,
    input wire sac_pwr_t power_mode_in,
    // Watched outputs
    input wire logic bus_clk_en_out,
    input wire logic [4:0] mux_channel_out,
    input wire logic temp_sensor_sel_out,
    input wire sac_csc1_t csc1_out,
    input wire sac_csc2_t csc2_out,
    input wire sac_cfg_t cfg_out,
    input wire logic [WIDTH-1:0] result_out,
    input wire logic conv_complete_flag_out,
    input wire logic active_out,
    input wire logic irq_out
);
    // Single clock domain
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    //////////////////////////////////////////
    gate_reset_a: assert property ($fell(rst_in) |-> bus_clk_en_out)
        else $error("gate clear after reset");
    gate_clear_a: assert property (gate_wr_in && !gate_data_in
        |=> !bus_clk_en_out) else $error("gate write ignored");
    gate_refuse_a: assert property (!bus_clk_en_out && csc1_wr_in
        && !gate_wr_in |=> $stable(csc1_out)) else $error("gated write");
    temp_route_a: assert property (temp_sensor_sel_out
        == (mux_channel_out == CH_TEMP)) else $error("temp route");
    irq_raise_a: assert property (conv_complete_flag_out
        && csc1_out.int_enable |-> ##[0:1] irq_out) else $error("no irq");
    width_eight_a: assert property ($rose(conv_complete_flag_out)
        && cfg_out.mode == MODE_8 |-> (result_out >> 8) == '0)
        else $error("upper bits set");
    single_idle_a: assert property ($rose(conv_complete_flag_out)
        && !csc1_out.continuous |-> !active_out) else $error("not idle");
    sw_start_a: assert property (csc1_wr_in && bus_clk_en_out
        && !csc2_out.trigger_select && power_mode_in != SAC_PWR_STOP2
        && csc1_in.channel_select != CH_DISABLED |=> active_out)
        else $error("no start");
    abort_off_a: assert property (csc1_wr_in && bus_clk_en_out
        && csc1_in.channel_select == CH_DISABLED |=> !active_out [*2])
        else $error("no abort");
    flag_clear_a: assert property (res_low_rd_in && bus_clk_en_out
        && !active_out |=> !conv_complete_flag_out) else $error("flag kept");
endmodule

bind sac_conv_ctrl sac_conv_ctrl_sva #(.WIDTH(WIDTH)) u_sva (.*);

// *** bench/sac_rtc_model.sv ***
// Far side model: RTC match trigger plus analog input and comparator.
// Assumes the system clock; level_in is the analog input as a code.
`timescale 1ns/100ps
module sac_rtc_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // RTC setup
    input wire logic run_in,
    input wire logic [3:0] modulo_in,
    // Analog side
    input wire logic [11:0] dac_code_in,
    input wire logic [11:0] level_in,
    output logic hw_trigger_out,
    output logic comparator_out
);
    logic [7:0] count;
    logic [7:0] next_count;
    // Prescaled: a match spans 16 cycles
    always_comb begin
        next_count = count + 8'h01;
        if (!run_in || count == {modulo_in, 4'hf}) begin
            next_count = 8'h00;
        end
    end
    // Count register
    always_ff @(posedge sys_clk_in) begin
        count <= rst_in ? 8'h00 : next_count;
    end
    // Match alone drives the trigger, no interrupt enable
    assign hw_trigger_out = run_in && count[7:4] == modulo_in;
    // Ideal comparator
    assign comparator_out = level_in >= dac_code_in;
endmodule

// *** bench/sac_conv_ctrl_tb.sv ***
// Self-checking bench for the converter control block.
// Assumes the RTC model supplies trigger and comparator.
`timescale 1ns/100ps
module sac_conv_ctrl_tb;
    import sac_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] wstb = 6'h00;
    logic gate_data_in = 1'b1;
    sac_csc1_t csc1_in = CSC1_RESET;
    sac_csc2_t csc2_in = CSC2_RESET;
    sac_cfg_t cfg_in = CFG_RESET;
    logic [11:0] cmp_val_in = 12'h000;
    logic [11:0] level_in = 12'hab5;
    logic [2:0] div = 3'h0;
    logic run_in = 1'b0;
    logic act_q = 1'b0;
    sac_pwr_t power_mode_in = SAC_PWR_RUN;
    logic hw, cmp, bus_en, temp, flag, active, irq, smp;
    logic [11:0] dac, result;
    logic [4:0] mux;
    sac_csc1_t csc1_o;
    sac_csc2_t csc2_o;
    sac_cfg_t cfg_o;
    int errors = 0;
    int compares = 0;
    int starts = 0;
    int s0;
    logic [1:0] modes[3] = '{MODE_8, MODE_10, MODE_12};
    logic [4:0] chans[7] = '{5'h00, 5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c};
    sac_pwr_t pws[3] = '{SAC_PWR_RUN, SAC_PWR_WAIT, SAC_PWR_STOP3};
    //////////////////////////////////////////
    sac_conv_ctrl u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .gate_wr_in(wstb[0]), .gate_data_in(gate_data_in),
        .bus_clk_en_out(bus_en), .csc1_wr_in(wstb[1]), .csc1_in(csc1_in),
        .csc2_wr_in(wstb[2]), .csc2_in(csc2_in), .cfg_wr_in(wstb[3]),
        .cfg_in(cfg_in), .cmp_val_wr_in(wstb[4]), .cmp_val_in(cmp_val_in),
        .res_low_rd_in(wstb[5]), .hw_trigger_input_in(hw),
        .local_async_clock_in(div[1]), .alternate_conv_clock_in(div[2]),
        .power_mode_in(power_mode_in), .comparator_in(cmp),
        .dac_code_out(dac), .sample_out(smp), .mux_channel_out(mux),
        .temp_sensor_sel_out(temp), .converter_on_out(), .csc1_out(csc1_o),
        .csc2_out(csc2_o), .cfg_out(cfg_o), .result_out(result),
        .conv_complete_flag_out(flag), .active_out(active), .irq_out(irq));
    sac_rtc_model u_rtc (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .run_in(run_in), .modulo_in(4'h7), .dac_code_in(dac),
        .level_in(level_in), .hw_trigger_out(hw), .comparator_out(cmp));
    // Clock, async sources, start count
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        div <= div + 3'h1;
        act_q <= smp;
        if (smp === 1'b1 && act_q === 1'b0) begin
            starts <= starts + 1;
        end
    end
    //////////////////////////////////////////
    task automatic chk(input logic [11:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    // Strobe k: gate, csc1, csc2, cfg, compare value, low byte read
    task automatic wr(input int k, input logic [11:0] d);
        @(posedge sys_clk_in);
        case (k)
            0: gate_data_in <= d[0];
            1: csc1_in <= d[6:0];
            2: csc2_in <= d[2:0];
            3: cfg_in <= d[3:0];
            default: cmp_val_in <= d;
        endcase
        wstb <= 6'h01 << k;
        @(posedge sys_clk_in);
        wstb <= 6'h00;
        #1;
    endtask
    // Bounded wait on completion
    task automatic conv(input logic [6:0] c, input logic [11:0] e,
                        input logic f, input logic r);
        int n;
        n = 0;
        wr(1, {5'h00, c});
        while (active !== 1'b0 && n < 3000) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        @(posedge sys_clk_in);
        #1;
        chk(12'(n < 3000), 12'h1, "hang");
        chk(12'(flag), 12'(f), "flag");
        chk(12'(irq), 12'(f & c[6]), "irq");
        if (r) begin
            chk(result, e, "result");
        end
    endtask
    function automatic logic [11:0] fmt(input logic [11:0] v, logic [1:0] m);
        return m == MODE_10 ? v >> 2 : m == MODE_8 ? v >> 4 : v;
    endfunction
    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    //////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        #1;
        chk(12'(bus_en), 12'h1, "gate reset");
        chk(12'(mux), 12'(CH_DISABLED), "mux reset");
        chk(12'({flag, active, irq}), 12'h0, "idle reset");
        foreach (modes[i]) begin
            wr(3, {8'h00, modes[i], CLK_BUS});
            conv(7'h43, fmt(12'hab5, modes[i]), 1'b1, 1'b1);
            wr(5, 12'h000);
            chk(12'(flag), 12'h0, "read clear");
        end
        $display("widths done");
        // Bandgap buffer assumed on
        foreach (chans[i]) begin
            conv({2'b00, chans[i]}, 12'hab5, 1'b1, chans[i] < CH_RSVD_A
                || chans[i] == CH_TEMP || chans[i] == CH_BANDGAP);
            chk(12'(mux), 12'(chans[i]), "mux");
            chk(12'(temp), 12'(chans[i] == CH_TEMP), "temp");
        end
        $display("channels done");
        for (int k = 0; k < 4; k++) begin
            wr(3, {8'h00, MODE_12, 2'(k)});
            conv(7'h03, 12'hab5, 1'b1, 1'b1);
        end
        $display("clocks done");
        wr(4, 12'hab5);
        wr(2, 12'h003);
        conv(7'h43, 12'hab5, 1'b1, 1'b1);
        wr(2, 12'h002);
        conv(7'h43, 12'hab5, 1'b0, 1'b0);
        wr(2, 12'h000);
        $display("compare done");
        wr(1, 12'h003);
        repeat (10) @(posedge sys_clk_in);
        wr(1, 12'h01f);
        chk(12'(active), 12'h0, "abort");
        repeat (80) @(posedge sys_clk_in);
        #1;
        chk(12'(flag), 12'h0, "aborted flag");
        s0 = starts;
        wr(1, 12'h023);
        repeat (200) @(posedge sys_clk_in);
        chk(12'(starts - s0 > 2), 12'h1, "continuous");
        wr(1, 12'h01f);
        chk(12'(active), 12'h0, "stop");
        $display("abort done");
        wr(2, 12'h004);
        wr(1, 12'h003);
        chk(12'(active), 12'h0, "hw no sw start");
        foreach (pws[i]) begin
            power_mode_in <= pws[i];
            s0 = starts;
            run_in <= 1'b1;
            repeat (200) @(posedge sys_clk_in);
            run_in <= 1'b0;
            #1;
            chk(12'(starts - s0), 12'h1, "one per match");
            chk(12'(flag), 12'h1, "hw flag");
            wr(5, 12'h000);
        end
        power_mode_in <= SAC_PWR_RUN;
        wr(2, 12'h000);
        $display("hardware trigger done");
        wr(0, 12'h000);
        chk(12'(bus_en), 12'h0, "gate off");
        wr(1, 12'h005);
        chk(12'(csc1_o), 12'h003, "gated write");
        wr(0, 12'h001);
        chk(12'(bus_en), 12'h1, "gate on");
        $display("gate done");
        close_out();
    end
    // Watchdog, far past the expected run
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        $display("mismatch %0t watchdog", $time);
        close_out();
    end
endmodule
